// File: inc/mmc_defines.vh
// Constants for the meter misc control register bank.
// Assumes byte-wide core register bus with separate SFR and memory spaces.
`ifndef MMC_DEFINES_VH
`define MMC_DEFINES_VH

// SFR space offsets
`define MMC_OFS_EE_DATA      16'h009e
`define MMC_OFS_EE_CTRL      16'h009f

// Memory-mapped offsets
`define MMC_OFS_EQU          16'h2106
`define MMC_OFS_EE_MODE      16'h2456
`define MMC_OFS_STEER_WV     16'h2457
`define MMC_OFS_STEER_XY     16'h2458
`define MMC_OFS_INT_LO       16'h2700
`define MMC_OFS_INT_HI       16'h2701
`define MMC_OFS_WAKE         16'h28b3

// Field positions
`define MMC_EQU_LSB          5
`define MMC_EE_MODE_LSB      6
`define MMC_BIT_STEER_W      7
`define MMC_BIT_STEER_V      6
`define MMC_BIT_STEER_X      7
`define MMC_BIT_STEER_Y      6
`define MMC_BIT_EE_ERR       7
`define MMC_BIT_EE_BUSY      6
`define MMC_BIT_EE_ACK       5
`define MMC_EE_CMD_W         5
`define MMC_BIT_WAKE_4       2
`define MMC_BIT_WAKE_52      1
`define MMC_BIT_WAKE_55      0

// Interrupt flag index (flag vector order) and byte/bit placement
`define MMC_NUM_INT          10
`define MMC_INT_XFER         0
`define MMC_INT_RTC1S        1
`define MMC_INT_RTC1M        2
`define MMC_INT_RTCT         3
`define MMC_INT_EE           4
`define MMC_INT_AUX_ENERGY_PULSE_X       5
`define MMC_INT_AUX_ENERGY_PULSE_Y       6
`define MMC_INT_SPI          7
`define MMC_INT_REAL_ENERGY_PULSE       8
`define MMC_INT_VPULSE       9
`define MMC_BIT_XFER         0
`define MMC_BIT_RTC1S        1
`define MMC_BIT_RTC1M        2
`define MMC_BIT_RTCT         3
`define MMC_BIT_EE           7
`define MMC_BIT_AUX_ENERGY_PULSE_X       6
`define MMC_BIT_AUX_ENERGY_PULSE_Y       5
`define MMC_BIT_SPI          7
`define MMC_BIT_REAL_ENERGY_PULSE       6
`define MMC_BIT_VPULSE       5

// EEPROM pin mode codes
`define MMC_EE_MODE_OFF      2'b00
`define MMC_EE_MODE_2W       2'b01
`define MMC_EE_MODE_3W       2'b10

// Reset values
`define MMC_RST_BYTE         8'h00
`define MMC_RST_EQU          3'h0
`define MMC_RST_MODE         2'h0

`endif

// File: rtl/mmc_int_flags.v
// Sticky interrupt flag bank, one flag per source.
// Assumes event inputs are one-cycle synchronous pulses.
`timescale 1ns/1ps

module mmc_int_flags
#(
  parameter N = 10
)
(
  input  wire         ref_clk,   // System clock
  input  wire         rst,       // Async reset, high
  input  wire         ce,        // Clock enable
  input  wire [N-1:0] set_ev,    // Hardware set events
  input  wire [N-1:0] clr,       // Software clear strobes
  output wire [N-1:0] flag       // Flag state
);

  reg [N-1:0] flag_q;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_flag
      always @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          flag_q[i] <= 1'b0;
        else if (ce)
        begin
          // Set beats a same-cycle clear so no event is lost
          if (set_ev[i])
            flag_q[i] <= 1'b1;
          else if (clr[i])
            flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flag = flag_q;

endmodule

// File: rtl/mmc_regs.v
// Meter misc control register bank: pulse steering, EEPROM regs,
// equation select, interrupt flags and pin wake enables.
// Assumes a byte-wide core bus with one-cycle strobes, synchronous pins.
`timescale 1ns/1ps
`include "mmc_defines.vh"

module mmc_regs
(
  input  wire        ref_clk,               // System clock, 100 MHz
  input  wire        rst,                   // Async reset, high
  input  wire        ce,                    // Clock enable, freezes state
  input  wire        bus_sfr,               // 1 selects SFR space
  input  wire [15:0] bus_addr,              // Register address
  input  wire        bus_wr,                // Write strobe
  input  wire        bus_rd,                // Read strobe
  input  wire [7:0]  bus_wdata,             // Write data
  output reg  [7:0]  bus_rdata_q,           // Read data
  output reg         bus_rvalid_q,          // Read data valid pulse
  input  wire [7:0]  lcd_pin_map,           // Pin-as-Lcd_pin_map bits
  input  wire        real_energy_pulse,     // Watt pulse
  input  wire        reactive_energy_pulse, // Var pulse
  input  wire        aux_energy_pulse_x,    // X pulse
  input  wire        aux_energy_pulse_y,    // Y pulse
  output reg  [3:0]  seg_pulse_oe_q,        // Drive enables pins 0,1,6,7
  output reg  [3:0]  seg_pulse_out_q,       // Pulse levels pins 0,1,6,7
  input  wire        ee_illegal_cmd,        // Engine saw illegal command
  input  wire        ee_bus_busy,           // Engine serial bus busy
  input  wire        ee_rx_ack,             // Acknowledge from memory
  input  wire        ee_rx_load,            // Engine loads received byte
  input  wire [7:0]  ee_rx_byte,            // Received byte
  output reg  [7:0]  ee_data_q,             // Data byte to engine
  output reg  [4:0]  ee_cmd_q,              // Command field to engine
  output reg         ee_cmd_stb_q,          // Command written pulse
  output reg         ee_two_wire_q,         // Two-wire mode on
  output reg         ee_three_wire_q,       // Three-wire mode on
  output reg  [2:0]  power_equation_select_q, // Equation select
  input  wire [9:0]  int_events,            // Source event pulses
  input  wire [9:0]  core_ext_en,           // Core external enables
  output reg  [9:0]  int_req_q,             // Gated requests to core
  input  wire        seg_io_pin_4,          // Pin 4 level
  input  wire        seg_io_pin_52,         // Pin 52 level
  input  wire        seg_io_pin_55,         // Pin 55 level
  input  wire        general_io_4_din,      // Io 4 is digital input
  input  wire        pin52_din,             // Pin 52 is digital input
  input  wire        pin55_din,             // Pin 55 is digital input
  output reg         wake_q                 // Wake request pulse
);

  function hit;
    input        sfr;
    input [15:0] addr;
    input        want_sfr;
    input [15:0] target;
    begin
      hit = (sfr == want_sfr) && (addr == target);
    end
  endfunction

  wire        h_data  = hit(bus_sfr, bus_addr, 1'b1, `MMC_OFS_EE_DATA);
  wire        h_ctrl  = hit(bus_sfr, bus_addr, 1'b1, `MMC_OFS_EE_CTRL);
  wire        h_equ   = hit(bus_sfr, bus_addr, 1'b0, `MMC_OFS_EQU);
  wire        h_mode  = hit(bus_sfr, bus_addr, 1'b0, `MMC_OFS_EE_MODE);
  wire        h_wv    = hit(bus_sfr, bus_addr, 1'b0, `MMC_OFS_STEER_WV);
  wire        h_xy    = hit(bus_sfr, bus_addr, 1'b0, `MMC_OFS_STEER_XY);
  wire        h_intlo = hit(bus_sfr, bus_addr, 1'b0, `MMC_OFS_INT_LO);
  wire        h_inthi = hit(bus_sfr, bus_addr, 1'b0, `MMC_OFS_INT_HI);
  wire        h_wake  = hit(bus_sfr, bus_addr, 1'b0, `MMC_OFS_WAKE);

  reg         steer_w_q;
  reg         steer_v_q;
  reg         steer_x_q;
  reg         steer_y_q;
  reg  [1:0]  ee_mode_q;
  reg         ee_err_q;
  reg         ee_busy_q;
  reg         ee_ack_q;
  reg         wake4_en_q;
  reg         wake52_en_q;
  reg         wake55_en_q;
  reg  [2:0]  pin_prev_q;

  // Interrupt flag bus layout
  wire [9:0]  int_flag;
  reg  [9:0]  int_clr;
  reg  [7:0]  int_lo_rd;
  reg  [7:0]  int_hi_rd;
  reg  [7:0]  rd_mux;

  // Map byte writes onto per-flag clears; ones are ignored
  always @*
  begin
    int_clr = 10'h000;
    if (bus_wr && h_intlo)
    begin
      int_clr[`MMC_INT_XFER]   = ~bus_wdata[`MMC_BIT_XFER];
      int_clr[`MMC_INT_RTC1S]  = ~bus_wdata[`MMC_BIT_RTC1S];
      int_clr[`MMC_INT_RTC1M]  = ~bus_wdata[`MMC_BIT_RTC1M];
      int_clr[`MMC_INT_RTCT]   = ~bus_wdata[`MMC_BIT_RTCT];
      int_clr[`MMC_INT_EE]     = ~bus_wdata[`MMC_BIT_EE];
      int_clr[`MMC_INT_AUX_ENERGY_PULSE_X] = ~bus_wdata[`MMC_BIT_AUX_ENERGY_PULSE_X];
      int_clr[`MMC_INT_AUX_ENERGY_PULSE_Y] = ~bus_wdata[`MMC_BIT_AUX_ENERGY_PULSE_Y];
    end
    if (bus_wr && h_inthi)
    begin
      int_clr[`MMC_INT_SPI]    = ~bus_wdata[`MMC_BIT_SPI];
      int_clr[`MMC_INT_REAL_ENERGY_PULSE] = ~bus_wdata[`MMC_BIT_REAL_ENERGY_PULSE];
      int_clr[`MMC_INT_VPULSE] = ~bus_wdata[`MMC_BIT_VPULSE];
    end
  end

  mmc_int_flags
  #(
    .N(`MMC_NUM_INT)
  )
  u_flags
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .set_ev  (int_events),
    .clr     (int_clr),
    .flag    (int_flag)
  );

  // Place flags into their bytes
  always @*
  begin
    int_lo_rd = `MMC_RST_BYTE;
    int_hi_rd = `MMC_RST_BYTE;
    int_lo_rd[`MMC_BIT_XFER]   = int_flag[`MMC_INT_XFER];
    int_lo_rd[`MMC_BIT_RTC1S]  = int_flag[`MMC_INT_RTC1S];
    int_lo_rd[`MMC_BIT_RTC1M]  = int_flag[`MMC_INT_RTC1M];
    int_lo_rd[`MMC_BIT_RTCT]   = int_flag[`MMC_INT_RTCT];
    int_lo_rd[`MMC_BIT_EE]     = int_flag[`MMC_INT_EE];
    int_lo_rd[`MMC_BIT_AUX_ENERGY_PULSE_X] = int_flag[`MMC_INT_AUX_ENERGY_PULSE_X];
    int_lo_rd[`MMC_BIT_AUX_ENERGY_PULSE_Y] = int_flag[`MMC_INT_AUX_ENERGY_PULSE_Y];
    int_hi_rd[`MMC_BIT_SPI]    = int_flag[`MMC_INT_SPI];
    int_hi_rd[`MMC_BIT_REAL_ENERGY_PULSE] = int_flag[`MMC_INT_REAL_ENERGY_PULSE];
    int_hi_rd[`MMC_BIT_VPULSE] = int_flag[`MMC_INT_VPULSE];
  end

  // Read multiplexer; unmapped addresses read zero
  always @*
  begin
    rd_mux = `MMC_RST_BYTE;
    if (h_data)
      rd_mux = ee_data_q;
    else if (h_ctrl)
    begin
      rd_mux[`MMC_EE_CMD_W-1:0] = ee_cmd_q;
      rd_mux[`MMC_BIT_EE_ERR]   = ee_err_q;
      rd_mux[`MMC_BIT_EE_BUSY]  = ee_busy_q;
      rd_mux[`MMC_BIT_EE_ACK]   = ee_ack_q;
    end
    else if (h_equ)
      rd_mux[`MMC_EQU_LSB+2:`MMC_EQU_LSB] = power_equation_select_q;
    else if (h_mode)
      rd_mux[`MMC_EE_MODE_LSB+1:`MMC_EE_MODE_LSB] = ee_mode_q;
    else if (h_wv)
    begin
      rd_mux[`MMC_BIT_STEER_W] = steer_w_q;
      rd_mux[`MMC_BIT_STEER_V] = steer_v_q;
    end
    else if (h_xy)
    begin
      rd_mux[`MMC_BIT_STEER_X] = steer_x_q;
      rd_mux[`MMC_BIT_STEER_Y] = steer_y_q;
    end
    else if (h_intlo)
      rd_mux = int_lo_rd;
    else if (h_inthi)
      rd_mux = int_hi_rd;
    else if (h_wake)
    begin
      rd_mux[`MMC_BIT_WAKE_4]  = wake4_en_q;
      rd_mux[`MMC_BIT_WAKE_52] = wake52_en_q;
      rd_mux[`MMC_BIT_WAKE_55] = wake55_en_q;
    end
  end

  // Bus read answer, one cycle after the strobe
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_rdata_q  <= `MMC_RST_BYTE;
      bus_rvalid_q <= 1'b0;
    end
    else if (ce)
    begin
      bus_rvalid_q <= bus_rd;
      if (bus_rd)
        bus_rdata_q <= rd_mux;
    end
  end

  // Writable configuration registers
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      steer_w_q               <= 1'b0;
      steer_v_q               <= 1'b0;
      steer_x_q               <= 1'b0;
      steer_y_q               <= 1'b0;
      ee_mode_q               <= `MMC_RST_MODE;
      power_equation_select_q <= `MMC_RST_EQU;
      wake4_en_q              <= 1'b0;
      wake52_en_q             <= 1'b0;
      wake55_en_q             <= 1'b0;
      ee_data_q               <= `MMC_RST_BYTE;
      ee_cmd_q                <= 5'h00;
      ee_cmd_stb_q            <= 1'b0;
    end
    else if (ce)
    begin
      ee_cmd_stb_q <= bus_wr && h_ctrl;
      if (bus_wr && h_wv)
      begin
        steer_w_q <= bus_wdata[`MMC_BIT_STEER_W];
        steer_v_q <= bus_wdata[`MMC_BIT_STEER_V];
      end
      if (bus_wr && h_xy)
      begin
        steer_x_q <= bus_wdata[`MMC_BIT_STEER_X];
        steer_y_q <= bus_wdata[`MMC_BIT_STEER_Y];
      end
      if (bus_wr && h_mode)
        ee_mode_q <= bus_wdata[`MMC_EE_MODE_LSB+1:`MMC_EE_MODE_LSB];
      if (bus_wr && h_equ)
        power_equation_select_q <= bus_wdata[`MMC_EQU_LSB+2:`MMC_EQU_LSB];
      if (bus_wr && h_wake)
      begin
        wake4_en_q  <= bus_wdata[`MMC_BIT_WAKE_4];
        wake52_en_q <= bus_wdata[`MMC_BIT_WAKE_52];
        wake55_en_q <= bus_wdata[`MMC_BIT_WAKE_55];
      end
      // Software write wins over a same-cycle engine load of the data byte
      if (bus_wr && h_data)
        ee_data_q <= bus_wdata;
      else if (ee_rx_load)
        ee_data_q <= ee_rx_byte;
      // Status bits are read-only; only the command field is stored
      if (bus_wr && h_ctrl)
        ee_cmd_q <= bus_wdata[`MMC_EE_CMD_W-1:0];
    end
  end

  // EEPROM status tracking and pin mode decode
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ee_err_q        <= 1'b0;
      ee_busy_q       <= 1'b0;
      ee_ack_q        <= 1'b0;
      ee_two_wire_q   <= 1'b0;
      ee_three_wire_q <= 1'b0;
    end
    else if (ce)
    begin
      // Error holds until the next command; a new illegal one still sets it
      if (ee_illegal_cmd)
        ee_err_q <= 1'b1;
      else if (bus_wr && h_ctrl)
        ee_err_q <= 1'b0;
      ee_busy_q       <= ee_bus_busy;
      ee_ack_q        <= ee_rx_ack;
      ee_two_wire_q   <= (ee_mode_q == `MMC_EE_MODE_2W);
      ee_three_wire_q <= (ee_mode_q == `MMC_EE_MODE_3W);
    end
  end

  // Pulse steering onto shared segment pins
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      seg_pulse_oe_q  <= 4'h0;
      seg_pulse_out_q <= 4'h0;
    end
    else if (ce)
    begin
      seg_pulse_oe_q[0]  <= steer_w_q & ~lcd_pin_map[0];
      seg_pulse_oe_q[1]  <= steer_v_q & ~lcd_pin_map[1];
      seg_pulse_oe_q[2]  <= steer_x_q & ~lcd_pin_map[6];
      seg_pulse_oe_q[3]  <= steer_y_q & ~lcd_pin_map[7];
      seg_pulse_out_q[0] <= steer_w_q & ~lcd_pin_map[0] & real_energy_pulse;
      seg_pulse_out_q[1] <= steer_v_q & ~lcd_pin_map[1] & reactive_energy_pulse;
      seg_pulse_out_q[2] <= steer_x_q & ~lcd_pin_map[6] & aux_energy_pulse_x;
      seg_pulse_out_q[3] <= steer_y_q & ~lcd_pin_map[7] & aux_energy_pulse_y;
    end
  end

  // Interrupt gating with the core's own enables
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      int_req_q <= 10'h000;
    else if (ce)
      int_req_q <= int_flag & core_ext_en;
  end

  // Rising-edge wake; edge history runs always so enabling never fakes an edge
  wire [2:0] pin_now = {seg_io_pin_55, seg_io_pin_52, seg_io_pin_4};
  wire [2:0] pin_rise = pin_now & ~pin_prev_q;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_prev_q <= 3'h0;
      wake_q     <= 1'b0;
    end
    else if (ce)
    begin
      pin_prev_q <= pin_now;
      wake_q     <= (pin_rise[0] & wake4_en_q & general_io_4_din)
                  | (pin_rise[1] & wake52_en_q & pin52_din)
                  | (pin_rise[2] & wake55_en_q & pin55_din);
    end
  end

endmodule

// File: test/mmc_regs_properties.sv
// Port checker for the mmc_regs register bank.
// Assumes it is bound to mmc_regs and that there is a single clock domain.
`timescale 1ns/1ps
module mmc_checker
(
  input wire        ref_clk,            // Clock
  input wire        rst,                // Reset
  input wire        ce,                 // Enable
  input wire        bus_sfr,            // Space
  input wire [15:0] bus_addr,           // Address
  input wire        bus_wr,             // Write
  input wire        bus_rd,             // Read
  input wire [7:0]  bus_wdata,          // Data in
  input wire [7:0]  bus_rdata_q,        // Data out
  input wire        bus_rvalid_q,       // Valid
  input wire [7:0]  lcd_pin_map,        // Map
  input wire        aux_energy_pulse_x, // X pulse
  input wire [3:0]  seg_pulse_oe_q,     // Enables
  input wire [3:0]  seg_pulse_out_q,    // Levels
  input wire        ee_two_wire_q,      // Mode
  input wire        ee_three_wire_q,    // Mode
  input wire [9:0]  int_events,         // Events
  input wire [9:0]  core_ext_en,        // Enables
  input wire [9:0]  int_req_q,          // Requests
  input wire        seg_io_pin_4,       // Pin
  input wire        seg_io_pin_52,      // Pin
  input wire        seg_io_pin_55,      // Pin
  input wire        general_io_4_din,   // Input mode
  input wire        pin52_din,          // Input mode
  input wire        pin55_din,          // Input mode
  input wire        wake_q              // Wake
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_ev; ce && (int_events != 10'h000); endsequence
  sequence s_ev_kept; s_ev ##1 ce; endsequence
  sequence s_clr_lo; ce && bus_wr && !bus_sfr && bus_addr == 16'h2700 && bus_wdata == 8'h00 && int_events == 10'h000;
  endsequence

  // Clock enable low freezes the valid flop, so it holds rather than drops
  property p_rvalid; 1'b1 |=> bus_rvalid_q == ($past(ce) ? $past(bus_rd) : $past(bus_rvalid_q)); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid not tied to read strobe");
  property p_rhold; !(ce && bus_rd) |=> $stable(bus_rdata_q); endproperty
  a_rhold: assert property (p_rhold) else $error("read data changed without a read");
  property p_map; ce |=> (seg_pulse_oe_q & $past({lcd_pin_map[7:6], lcd_pin_map[1:0]})) == 4'h0; endproperty
  a_map: assert property (p_map) else $error("pulse driven on a pin mapped to the display");
  property p_xfol; $past(ce) && seg_pulse_oe_q[2] |-> seg_pulse_out_q[2] == $past(aux_energy_pulse_x); endproperty
  a_xfol: assert property (p_xfol) else $error("pin 6 level does not follow the x pulse");
  property p_outoe; (seg_pulse_out_q & ~seg_pulse_oe_q) == 4'h0; endproperty
  a_outoe: assert property (p_outoe) else $error("pulse level on an undriven pin");
  property p_mode; !(ee_two_wire_q && ee_three_wire_q); endproperty
  a_mode: assert property (p_mode) else $error("both serial modes on");
  property p_gate; $past(ce) |-> (int_req_q & ~$past(core_ext_en)) == 10'h000; endproperty
  a_gate: assert property (p_gate) else $error("request passed without core enable");
  property p_set; s_ev_kept |=> (int_req_q & $past(int_events, 2) & $past(core_ext_en))
    == ($past(int_events, 2) & $past(core_ext_en)); endproperty
  a_set: assert property (p_set) else $error("event did not raise its request");
  property p_clr; s_clr_lo ##1 ce |=> int_req_q[6:0] == 7'h00; endproperty
  a_clr: assert property (p_clr) else $error("zero write left a low byte request");
  property p_wake; $past(ce) && wake_q |-> ($past(seg_io_pin_4 && general_io_4_din) && !$past(seg_io_pin_4, 2))
    || ($past(seg_io_pin_52 && pin52_din) && !$past(seg_io_pin_52, 2))
    || ($past(seg_io_pin_55 && pin55_din) && !$past(seg_io_pin_55, 2)); endproperty
  a_wake: assert property (p_wake) else $error("wake without a qualified rising pin");
endmodule

// File: test/mmc_core_model.sv
// Core-side bus master model for the mmc_regs register bus.
// Assumes requests launch on falling edges and reads answer one edge later.
`timescale 1ns/1ps
module mmc_core_model
(
  input  wire        ref_clk,      // Clock
  output reg         bus_sfr,      // Space select
  output reg  [15:0] bus_addr,     // Address
  output reg         bus_wr,       // Write strobe
  output reg         bus_rd,       // Read strobe
  output reg  [7:0]  bus_wdata,    // Write data
  input  wire [7:0]  bus_rdata_q,  // Read data
  input  wire        bus_rvalid_q  // Read valid
);
  integer gap = 0;
  initial
  begin
    {bus_sfr, bus_addr, bus_wr, bus_rd, bus_wdata} = 27'h0;
  end
  // Released address and data lines flip so a stale value can never pass for a live one
  task drop;
  begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = ~bus_addr;
    bus_wdata = ~bus_wdata;
    repeat (gap) @(negedge ref_clk);
  end
  endtask
  task wr(input s, input [15:0] a, input [7:0] d);
  begin
    @(negedge ref_clk);
    {bus_sfr, bus_addr, bus_wdata, bus_wr} = {s, a, d, 1'b1};
    @(negedge ref_clk);
    drop;
  end
  endtask
  task rd(input s, input [15:0] a, output [7:0] d);
    integer n;
  begin
    @(negedge ref_clk);
    {bus_sfr, bus_addr, bus_rd} = {s, a, 1'b1};
    @(negedge ref_clk);
    for (n = 0; n < 4 && bus_rvalid_q !== 1'b1; n++) @(negedge ref_clk);
    d = (n < 4) ? bus_rdata_q : 8'hxx;
    drop;
  end
  endtask
endmodule

// File: test/meter_misc_control_registers_tb_top.sv
// Self-checking bench for the mmc_regs register bank.
// Assumes mmc_core_model drives the bus; other inputs change on falling edges.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end
module meter_misc_control_registers_tb_top;
  reg         ref_clk = 1'b0, rst = 1'b1, ce = 1'b1;
  reg  [7:0]  lcd_pin_map = 8'h00, ee_rx_byte = 8'h00, rv;
  reg         real_energy_pulse = 1'b0, reactive_energy_pulse = 1'b0;
  reg         aux_energy_pulse_x = 1'b0, aux_energy_pulse_y = 1'b0;
  reg         ee_illegal_cmd = 1'b0, ee_bus_busy = 1'b0, ee_rx_ack = 1'b0, ee_rx_load = 1'b0;
  reg  [9:0]  int_events = 10'h000, core_ext_en = 10'h000;
  reg         seg_io_pin_4 = 1'b0, seg_io_pin_52 = 1'b0, seg_io_pin_55 = 1'b0;
  reg         general_io_4_din = 1'b0, pin52_din = 1'b0, pin55_din = 1'b0;
  wire        bus_sfr, bus_wr, bus_rd, bus_rvalid_q, ee_cmd_stb_q, ee_two_wire_q, ee_three_wire_q, wake_q;
  wire [15:0] bus_addr;
  wire [7:0]  bus_wdata, bus_rdata_q, ee_data_q;
  wire [3:0]  seg_pulse_oe_q, seg_pulse_out_q;
  wire [4:0]  ee_cmd_q;
  wire [2:0]  power_equation_select_q;
  wire [9:0]  int_req_q;
  integer     errors = 0, num_checks = 0, wake_cnt = 0, m;
  localparam [111:0] mem_tab = {16'h28b3, 16'h2701, 16'h2700, 16'h2458, 16'h2457, 16'h2456, 16'h2106};

  mmc_regs       uut (.*);
  mmc_core_model core (.*);

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wake_q === 1'b1) wake_cnt <= wake_cnt + 1;

  task step(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  task rdchk(input s, input [15:0] a, input [7:0] mk, input [7:0] e);
  begin
    core.rd(s, a, rv);
    `CHK(rv & mk, e)
  end
  endtask
  task rise(input integer p, input integer exp);
    integer c0;
  begin
    c0 = wake_cnt;
    step(2);
    case (p) 4: seg_io_pin_4 = 1'b1; 52: seg_io_pin_52 = 1'b1; default: seg_io_pin_55 = 1'b1; endcase
    step(3);
    {seg_io_pin_4, seg_io_pin_52, seg_io_pin_55} = 3'b000;
    `CHK(wake_cnt - c0, exp)
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  initial
  begin
    #100000;
    errors++;
    $display("watchdog expired");
    results;
  end

  initial
  begin
    step(16);
    rst = 1'b0;
    step(1);
    rdchk(1'b1, 16'h009e, 8'hff, 8'h00);
    rdchk(1'b1, 16'h009f, 8'hff, 8'h00);
    for (m = 0; m < 7; m++) rdchk(1'b0, mem_tab[m*16 +: 16], 8'hff, 8'h00);
    $display("test reset values done");
    core.wr(1'b0, 16'h2106, 8'hff);
    `CHK(power_equation_select_q, 3'h7)
    ce = 1'b0;
    core.wr(1'b0, 16'h2106, 8'h00);
    ce = 1'b1;
    rdchk(1'b0, 16'h2106, 8'hff, 8'he0);
    rdchk(1'b1, 16'h2106, 8'hff, 8'h00);
    core.gap = 3;
    core.wr(1'b0, 16'h2459, 8'hff);
    rdchk(1'b0, 16'h2459, 8'hff, 8'h00);
    core.gap = 0;
    core.wr(1'b1, 16'h009e, 8'ha5);
    `CHK(ee_data_q, 8'ha5)
    rdchk(1'b1, 16'h009e, 8'hff, 8'ha5);
    {ee_rx_byte, ee_rx_load} = {8'h3c, 1'b1};
    step(1);
    ee_rx_load = 1'b0;
    rdchk(1'b1, 16'h009e, 8'hff, 8'h3c);
    $display("test data registers done");
    for (m = 0; m < 4; m++)
    begin
      core.wr(1'b0, 16'h2456, m[1:0] << 6);
      rdchk(1'b0, 16'h2456, 8'hff, m[1:0] << 6);
      `CHK({ee_three_wire_q, ee_two_wire_q}, (m == 1) ? 2'b01 : (m == 2) ? 2'b10 : 2'b00)
    end
    core.wr(1'b1, 16'h009f, 8'hff);
    `CHK(ee_cmd_q, 5'h1f)
    `CHK(ee_cmd_stb_q, 1'b1)
    rdchk(1'b1, 16'h009f, 8'he0, 8'h00);
    `CHK(ee_cmd_stb_q, 1'b0)
    {ee_bus_busy, ee_rx_ack} = 2'b11;
    step(2);
    rdchk(1'b1, 16'h009f, 8'he0, 8'h60);
    ee_illegal_cmd = 1'b1;
    step(1);
    ee_illegal_cmd = 1'b0;
    rdchk(1'b1, 16'h009f, 8'he0, 8'he0);
    {ee_bus_busy, ee_rx_ack} = 2'b00;
    core.wr(1'b1, 16'h009f, 8'h00);
    rdchk(1'b1, 16'h009f, 8'he0, 8'h00);
    $display("test serial memory registers done");
    {aux_energy_pulse_x, real_energy_pulse} = 2'b11;
    core.wr(1'b0, 16'h2458, 8'hc0);
    core.wr(1'b0, 16'h2457, 8'hc0);
    step(3);
    `CHK(seg_pulse_oe_q, 4'hf)
    `CHK(seg_pulse_out_q, 4'h5)
    lcd_pin_map = 8'hc3;
    step(2);
    `CHK(seg_pulse_oe_q, 4'h0)
    {lcd_pin_map, aux_energy_pulse_y} = {8'h40, 1'b1};
    step(2);
    `CHK(seg_pulse_out_q, 4'h9)
    rdchk(1'b0, 16'h2458, 8'hff, 8'hc0);
    core.wr(1'b0, 16'h2458, 8'h00);
    step(3);
    `CHK(seg_pulse_oe_q, 4'h3)
    $display("test pulse steering done");
    {core_ext_en, int_events} = {10'h3ff, 10'h3ff};
    step(1);
    int_events = 10'h000;
    step(2);
    `CHK(int_req_q, 10'h3ff)
    rdchk(1'b0, 16'h2700, 8'hff, 8'hef);
    rdchk(1'b0, 16'h2701, 8'hff, 8'he0);
    core.wr(1'b0, 16'h2700, 8'hff);
    rdchk(1'b0, 16'h2700, 8'hff, 8'hef);
    core.wr(1'b0, 16'h2700, 8'h00);
    rdchk(1'b0, 16'h2700, 8'hff, 8'h00);
    `CHK(int_req_q, 10'h380)
    core_ext_en = 10'h100;
    step(2);
    `CHK(int_req_q, 10'h100)
    rdchk(1'b0, 16'h2701, 8'hff, 8'he0);
    core.wr(1'b0, 16'h2701, 8'h00);
    rdchk(1'b0, 16'h2701, 8'hff, 8'h00);
    $display("test interrupt bits done");
    core.wr(1'b0, 16'h28b3, 8'h07);
    rdchk(1'b0, 16'h28b3, 8'hff, 8'h07);
    rise(4, 0);
    general_io_4_din = 1'b1;
    rise(4, 1);
    rise(52, 0);
    {pin52_din, pin55_din} = 2'b11;
    rise(52, 1);
    rise(55, 1);
    core.wr(1'b0, 16'h28b3, 8'h00);
    rise(4, 0);
    $display("test wake enables done");
    results;
  end
endmodule

bind mmc_regs mmc_checker chk (.*);
